// File: phy_loop_ctrl.sv
// loopback and test-mode control with management registers and gmii loop path
// Functional notes
// - loopback select in 3.518 bits 12..10
// - media loopback returns tx transactions unchanged
// - tx error returns as rx error
// - 1.0 bit 15 resets media, self-clears
// - 1.1 bit 2 link up after reset, only with media loopback selected
// - test-mode field 15..13, resets to 000
// - test-mode values 001..110 read back
// - 3.0 bit 15 resets coding, self-clears
// - selections only via management interface
// - loopback field resets 000; 001 gmii
// - test mode 001 zero payload, gmii ignored
// - test mode 010 alternating +1/-1 symbols
`timescale 1ns/1ps
module phy_loop_ctrl
  import phy_loop_pkg::*;
#(
  parameter int RST_CYCLES = phy_loop_pkg::RESET_CYCLES,
  parameter int RX_CLK_DIV = phy_loop_pkg::RX_DIV,
  parameter int SYM_DIV = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mgmtWrEn,
  input wire logic mgmtRdEn,
  input wire logic [4:0] mgmtDevad,
  input wire logic [15:0] mgmtRegAddr,
  input wire logic [15:0] mgmtWrData,
  output logic [15:0] mgmtRdData,
  output logic mgmtRdValid,
  input wire logic gtxClk,
  input wire logic [7:0] txData,
  input wire logic txEn,
  input wire logic txEr,
  output logic rxClk,
  output logic [7:0] rxData,
  output logic rxDv,
  output logic rxEr,
  output logic [1:0] txSymbol,
  output logic linkUp,
  output logic fifoOverflow
);
  import phy_loop_pkg::*;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] testReg_reg; // register 3.518 image
  logic [15:0] pmaCnt_reg; // media reset countdown
  logic [15:0] pcsCnt_reg; // coding reset countdown
  logic [15:0] rdData_reg; // read answer
  logic rdValid_reg; // read strobe
  logic [3:0] clkSync_reg; // gtx clock: two sync stages plus history
  logic [9:0] dataSync1_reg; // first sync stage of data pins
  logic [9:0] dataSync2_reg; // second sync stage of data pins
  logic [15:0] rxDiv_reg; // rx pacing divider
  logic rxClk_reg, rxDv_reg, rxEr_reg;
  logic [7:0] rxData_reg;
  logic [15:0] symDiv_reg; // symbol pacing divider
  logic [1:0] sym_reg; // test symbol
  logic link_reg; // link status
  logic ovf_reg; // sticky overflow

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire hitPmaCtrl = (mgmtDevad == PMA_DEVAD) && (mgmtRegAddr == CTRL_REG_ADDR);
  wire hitPmaStat = (mgmtDevad == PMA_DEVAD) && (mgmtRegAddr == STAT_REG_ADDR);
  wire hitPcsCtrl = (mgmtDevad == PCS_DEVAD) && (mgmtRegAddr == CTRL_REG_ADDR);
  wire hitTest = (mgmtDevad == PCS_DEVAD) && (mgmtRegAddr == TEST_REG_ADDR);
  wire pmaBusy = (pmaCnt_reg != '0);
  wire pcsBusy = (pcsCnt_reg != '0);
  wire [2:0] loopSel = testReg_reg[LOOP_LSB +: 3];
  wire [2:0] testMode = testReg_reg[TEST_LSB +: 3];
  // both loopback selections route tx straight back to rx
  wire loopOn = (loopSel == LOOP_PMD) || (loopSel == LOOP_GMII);
  wire gmiiIgnored = (testMode == TEST_ZERO);
  wire flush = pmaBusy || pcsBusy || !loopOn;
  wire [15:0] rdMux = hitTest ? testReg_reg
    : hitPmaCtrl ? (16'h0000 | (16'(pmaBusy) << RESET_BIT))
    : hitPcsCtrl ? (16'h0000 | (16'(pcsBusy) << RESET_BIT))
    : hitPmaStat ? (16'h0000 | (16'(link_reg) << LINK_BIT))
    : 16'h0000;

  // ----------------------------------------------------------------
  // management registers
  // ----------------------------------------------------------------
  // the whole word is stored so untouched bits survive a read-modify-write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      testReg_reg <= TEST_REG_RESET;
    else if (mgmtWrEn && hitTest)
      testReg_reg <= mgmtWrData;
  end

  // self-clearing media reset, reads one while running
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pmaCnt_reg <= '0;
    else if (mgmtWrEn && hitPmaCtrl && mgmtWrData[RESET_BIT])
      pmaCnt_reg <= 16'(RST_CYCLES);
    else if (pmaBusy)
      pmaCnt_reg <= pmaCnt_reg - 16'h0001;
  end

  // self-clearing coding reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pcsCnt_reg <= '0;
    else if (mgmtWrEn && hitPcsCtrl && mgmtWrData[RESET_BIT])
      pcsCnt_reg <= 16'(RST_CYCLES);
    else if (pcsBusy)
      pcsCnt_reg <= pcsCnt_reg - 16'h0001;
  end

  // read answer one cycle after the request
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdData_reg <= '0;
      rdValid_reg <= 1'b0;
    end
    else
    begin
      rdValid_reg <= mgmtRdEn;
      if (mgmtRdEn)
        rdData_reg <= rdMux;
    end
  end

  // link comes up once media loopback is chosen and no reset is running
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      link_reg <= 1'b0;
    else
      link_reg <= (loopSel == LOOP_PMD) && !pmaBusy && !pcsBusy;
  end

  // ----------------------------------------------------------------
  // gmii transmit sampling
  // ----------------------------------------------------------------
  // data is taken at the falling edge of the link clock, mid-bit,
  // because it changes right after the rising edge
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      clkSync_reg <= '0;
      dataSync1_reg <= '0;
      dataSync2_reg <= '0;
    end
    else
    begin
      clkSync_reg <= {clkSync_reg[2:0], gtxClk};
      dataSync1_reg <= {txEr, txEn, txData};
      dataSync2_reg <= dataSync1_reg;
    end
  end
  wire txFall = clkSync_reg[2] && !clkSync_reg[1];
  wire pushValid = txFall && !gmiiIgnored;
  wire fifoInReady;
  wire [9:0] fifoOut;
  wire fifoOutValid;
  logic [15:0] rxDivNext;
  assign rxDivNext = (rxDiv_reg == 16'(RX_CLK_DIV - 1)) ? 16'h0000 : rxDiv_reg + 16'h0001;
  wire rxTick = (rxDiv_reg == 16'h0000);
  wire rxHalf = (rxDiv_reg == 16'(RX_CLK_DIV / 2));

  // the fifo absorbs the phase slip between tx sampling and rx pacing
  loop_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(flush),
    .inData(dataSync2_reg),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(rxTick)
  );

  // a gmii source cannot be stalled; a refused word is flagged instead
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ovf_reg <= 1'b0;
    else if (pushValid && !fifoInReady)
      ovf_reg <= 1'b1;
    else if (pmaBusy)
      ovf_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // gmii receive side
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rxDiv_reg <= '0;
    else
      rxDiv_reg <= rxDivNext;
  end

  // each tick presents one word; empty fifo gives idle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rxClk_reg <= 1'b0;
      rxData_reg <= '0;
      rxDv_reg <= 1'b0;
      rxEr_reg <= 1'b0;
    end
    else if (rxTick)
    begin
      rxClk_reg <= 1'b0;
      rxData_reg <= fifoOutValid ? fifoOut[7:0] : 8'h00;
      rxDv_reg <= fifoOutValid && fifoOut[8];
      rxEr_reg <= fifoOutValid && fifoOut[9];
    end
    else if (rxHalf)
      rxClk_reg <= 1'b1;
  end

  // ----------------------------------------------------------------
  // test-mode symbol source
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      symDiv_reg <= '0;
      sym_reg <= SYM_ZERO;
    end
    else
    begin
      symDiv_reg <= (symDiv_reg == 16'(SYM_DIV - 1)) ? 16'h0000 : symDiv_reg + 16'h0001;
      if (symDiv_reg == 16'h0000)
      begin
        if (testMode == TEST_SQUARE)
          sym_reg <= (sym_reg == SYM_PLUS) ? SYM_MINUS : SYM_PLUS;
        else
          sym_reg <= SYM_ZERO;
      end
    end
  end

  assign mgmtRdData = rdData_reg;
  assign mgmtRdValid = rdValid_reg;
  assign rxClk = rxClk_reg;
  assign rxData = rxData_reg;
  assign rxDv = rxDv_reg;
  assign rxEr = rxEr_reg;
  assign txSymbol = sym_reg;
  assign linkUp = link_reg;
  assign fifoOverflow = ovf_reg;
endmodule

// File: phy_loop_pkg.sv
// constants shared by the loopback / test-mode control block
package phy_loop_pkg;
  // ----------------------------------------------------------------
  // management addressing
  // ----------------------------------------------------------------
  localparam logic [4:0] PMA_DEVAD = 5'h01; // media attachment device
  localparam logic [4:0] PCS_DEVAD = 5'h03; // coding sublayer device
  localparam logic [15:0] CTRL_REG_ADDR = 16'h0000; // control register (x.0)
  localparam logic [15:0] STAT_REG_ADDR = 16'h0001; // status register (x.1)
  localparam logic [15:0] TEST_REG_ADDR = 16'h0206; // 3.518 test/loopback register
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RESET_BIT = 15; // self-clearing reset bit in x.0
  localparam int LINK_BIT = 2; // link status bit in 1.1
  localparam int LOOP_LSB = 10; // loopback select 12..10
  localparam int TEST_LSB = 13; // test-mode select 15..13
  localparam logic [15:0] TEST_REG_RESET = 16'h0000; // reset value of 3.518
  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] LOOP_NONE = 3'h0; // no loopback
  localparam logic [2:0] LOOP_GMII = 3'h1; // loopback at the GMII side
  localparam logic [2:0] LOOP_PMD = 3'h2; // loopback at the media side
  localparam logic [2:0] TEST_ZERO = 3'h1; // all-zero payload blocks
  localparam logic [2:0] TEST_SQUARE = 3'h2; // alternating +1/-1 symbols
  // ----------------------------------------------------------------
  // symbol codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SYM_ZERO = 2'h0; // symbol 0
  localparam logic [1:0] SYM_PLUS = 2'h1; // symbol +1
  localparam logic [1:0] SYM_MINUS = 2'h3; // symbol -1
  localparam int SYS_CLK_MHZ = 200; // system clock rate
  localparam int RESET_TIME_NS = 100; // duration of a self-clearing reset
  localparam int RESET_CYCLES = (RESET_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int LINK_PERIOD_NS = 125; // nominal GMII clock period
  localparam int RX_DIV = (LINK_PERIOD_NS * SYS_CLK_MHZ) / 1000;
  localparam int FIFO_WIDTH = 10; // {er, en, data}
  localparam int FIFO_DEPTH = 16;
endpackage

// File: loop_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module loop_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage array
  logic [AW-1:0] wrPtr_reg; // write index
  logic [AW-1:0] rdPtr_reg; // read index
  logic [AW:0] count_reg; // fill level
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;
  assign inReady = (count_reg != (AW+1)'(DEPTH)); // honest full
  assign outValid = (count_reg != '0); // honest empty
  assign outData = mem[rdPtr_reg];

  // ----------------------------------------------------------------
  // pointers and level
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else if (flush)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      if (doPop)
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  // data array carries no reset, it is qualified by the level
  always_ff @(posedge sys_clk)
  begin
    if (doPush)
      mem[wrPtr_reg] <= inData;
  end
endmodule

// File: phy_loop_asserts.sv
// concurrent checks on the ports of the loopback and test-mode block
`timescale 1ns/1ps
module phy_loop_asserts
  import phy_loop_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mgmtWrEn,
  input wire logic mgmtRdEn,
  input wire logic [4:0] mgmtDevad,
  input wire logic [15:0] mgmtRegAddr,
  input wire logic [15:0] mgmtWrData,
  input wire logic [15:0] mgmtRdData,
  input wire logic mgmtRdValid,
  input wire logic [1:0] txSymbol,
  input wire logic linkUp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // access decode and a shadow of the selection fields
  // ----------------------------------------------------------------
  wire testHit = mgmtDevad == PCS_DEVAD && mgmtRegAddr == TEST_REG_ADDR; // 3.518
  wire ctrlHit = mgmtDevad == PMA_DEVAD && mgmtRegAddr == CTRL_REG_ADDR; // 1.0
  logic [2:0] loopSel_reg; // loopback field as last written
  logic [2:0] testSel_reg; // test-mode field as last written
  // shadow follows writes so the mode checks know what is selected
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      loopSel_reg <= LOOP_NONE;
      testSel_reg <= 3'h0;
    end
    else if (mgmtWrEn && testHit)
    begin
      loopSel_reg <= mgmtWrData[12:10];
      testSel_reg <= mgmtWrData[15:13];
    end
  end
  // ----------------------------------------------------------------
  // steps of management transfers
  // ----------------------------------------------------------------
  sequence wrTest_s; mgmtWrEn && testHit; endsequence
  sequence rdTest_s; mgmtRdEn && testHit; endsequence
  sequence medRst_s; mgmtWrEn && ctrlHit && mgmtWrData[RESET_BIT]; endsequence
  sequence rdCtrl_s; mgmtRdEn && ctrlHit; endsequence
  read_answer_a: assert property (mgmtRdEn |=> mgmtRdValid)
    else $error("read not answered");
  valid_cause_a: assert property (mgmtRdValid |-> $past(mgmtRdEn))
    else $error("read answer without request");
  data_hold_a: assert property (!mgmtRdValid |-> $stable(mgmtRdData))
    else $error("read data moved without answer");
  test_readback_a: assert property (wrTest_s ##2 rdTest_s |=>
    mgmtRdData == $past(mgmtWrData, 3))
    else $error("test register read back differs");
  busy_read_a: assert property (medRst_s ##2 rdCtrl_s |=> mgmtRdData == 16'h8000)
    else $error("media reset bit not busy");
  link_down_a: assert property (medRst_s |-> ##2 (!linkUp)[*3])
    else $error("link up while reset runs");
  link_loop_a: assert property (linkUp |-> $past(loopSel_reg) == LOOP_PMD)
    else $error("link up without media loopback");
  square_a: assert property ((testSel_reg == TEST_SQUARE)[*4] |->
    (txSymbol == SYM_PLUS || txSymbol == SYM_MINUS) && txSymbol != $past(txSymbol))
    else $error("square wave symbol wrong");
  sym_idle_a: assert property ((testSel_reg != TEST_SQUARE)[*4] |-> txSymbol == SYM_ZERO)
    else $error("symbol outside square mode");
endmodule
bind phy_loop_ctrl phy_loop_asserts chk (.sys_clk(sys_clk), .rst(rst), .mgmtWrEn(mgmtWrEn),
  .mgmtRdEn(mgmtRdEn), .mgmtDevad(mgmtDevad), .mgmtRegAddr(mgmtRegAddr),
  .mgmtWrData(mgmtWrData), .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid),
  .txSymbol(txSymbol), .linkUp(linkUp));

// File: gmii_station.sv
// gmii transmit station sending test frames toward the block
`timescale 1ns/1ps
module gmii_station (
  output logic gtxClk,
  output logic [7:0] txData,
  output logic txEn,
  output logic txEr
);
  logic [8:0] sentQ[$]; // {er, data} of every enabled transaction
  // clock stands still low between frames
  initial
  begin
    gtxClk = 1'b0;
    txData = 8'h00;
    txEn = 1'b0;
    txEr = 1'b0;
  end
  // one transaction: changed at the rising edge, held for the full period
  task automatic put(input logic en, input logic er, input logic [7:0] d);
    gtxClk = 1'b1;
    txEn = en;
    txEr = er;
    txData = en ? d : ~txData; // idle data is meaningless, so keep it moving
    if (en)
      sentQ.push_back({er, d});
    #62.5 gtxClk = 1'b0;
    #62.5;
  endtask
  // one octet of the reflected check polynomial
  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r >> 1) ^ (32'hedb88320 & {32{r[0] ^ d[i]}});
    return r;
  endfunction
  // preamble, delimiter, payload, check octets and idle gap
  task automatic frame(input int len, input logic bad);
    logic [31:0] crc;
    logic [7:0] d;
    // step off the system clock grid so no link edge meets a sampling edge
    #1;
    crc = 32'hffffffff;
    for (int i = 0; i < 7; i++) put(1'b1, 1'b0, 8'h55);
    put(1'b1, 1'b0, 8'hd5);
    for (int i = 0; i < len; i++)
    begin
      d = (i % 2) ? 8'ha5 : 8'h5a;
      if (bad && i == len - 1) d = 8'h00;
      crc = crcStep(crc, d);
      put(1'b1, bad && i == len - 1, d);
    end
    crc = bad ? crc : ~crc; // uninverted value is a wrong
    for (int i = 0; i < 4; i++) put(1'b1, 1'b0, crc[8*i +: 8]);
    for (int i = 0; i < 12; i++) put(1'b0, 1'b0, 8'h00);
  endtask
endmodule

// File: testbench.sv
// self-checking bench for the loopback and test-mode control block
`timescale 1ns/1ps
module testbench;
  import phy_loop_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic mgmtWrEn = 1'b0;
  logic mgmtRdEn = 1'b0;
  logic [4:0] mgmtDevad = 5'h00;
  logic [15:0] mgmtRegAddr = 16'h0000;
  logic [15:0] mgmtWrData = 16'h0000;
  logic [15:0] mgmtRdData, q;
  logic mgmtRdValid, gtxClk, txEn, txEr, rxClk, rxDv, rxEr, linkUp, fifoOverflow;
  logic [7:0] txData, rxData;
  logic [1:0] txSymbol;
  logic [8:0] rxQ[$]; // {er, data} of every valid received transaction
  int err_count = 0;
  int comparisons = 0;
  always #2.5 sys_clk = ~sys_clk;
  gmii_station station (.gtxClk(gtxClk), .txData(txData), .txEn(txEn), .txEr(txEr));
  phy_loop_ctrl #(.RST_CYCLES(8)) dut (.sys_clk(sys_clk), .rst(rst), .mgmtWrEn(mgmtWrEn),
    .mgmtRdEn(mgmtRdEn), .mgmtDevad(mgmtDevad), .mgmtRegAddr(mgmtRegAddr),
    .mgmtWrData(mgmtWrData), .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid),
    .gtxClk(gtxClk), .txData(txData), .txEn(txEn), .txEr(txEr), .rxClk(rxClk),
    .rxData(rxData), .rxDv(rxDv), .rxEr(rxEr), .txSymbol(txSymbol), .linkUp(linkUp),
    .fifoOverflow(fifoOverflow));
  // data settles at the falling rx clock, so the rising one is safe
  always @(posedge rxClk)
    if (rxDv === 1'b1)
      rxQ.push_back({rxEr, rxData});
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write pulse launched at the falling edge
  task automatic wr(input logic [4:0] dv, input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    mgmtWrEn = 1'b1;
    mgmtDevad = dv;
    mgmtRegAddr = a;
    mgmtWrData = d;
    @(negedge sys_clk);
    mgmtWrEn = 1'b0;
  endtask
  // read pulse; the answer stands for the one cycle after the taking edge
  task automatic rd(input logic [4:0] dv, input logic [15:0] a);
    @(negedge sys_clk);
    mgmtRdEn = 1'b1;
    mgmtDevad = dv;
    mgmtRegAddr = a;
    @(negedge sys_clk);
    chk({15'h0, mgmtRdValid}, 16'h0001);
    q = mgmtRdData;
    mgmtRdEn = 1'b0;
  endtask
  // bounded poll of one bit; running out ends the run
  task automatic poll(input logic [4:0] dv, input logic [15:0] a, input int b, input logic v);
    for (int i = 0; i < 200; i++)
    begin
      rd(dv, a);
      if (q[b] === v)
        return;
    end
    err_count++;
    $display("[ERR] %0t poll ran out", $time);
    complete_run();
  endtask
  task automatic resetDefaults();
    rd(PCS_DEVAD, TEST_REG_ADDR);
    chk(q, TEST_REG_RESET);
    chk({15'h0, linkUp}, 16'h0000);
  endtask
  // test modes 001 to 110 with neighbouring bits set, then a coding reset
  task automatic testModes();
    for (int v = 1; v < 7; v++)
    begin
      wr(PCS_DEVAD, TEST_REG_ADDR, {v[2:0], 13'h0155});
      rd(PCS_DEVAD, TEST_REG_ADDR);
      chk(q, {v[2:0], 13'h0155});
    end
    wr(PCS_DEVAD, TEST_REG_ADDR, {TEST_SQUARE, 13'h0});
    repeat (10) @(negedge sys_clk);
    wr(PCS_DEVAD, CTRL_REG_ADDR, 16'h8000);
    rd(PCS_DEVAD, CTRL_REG_ADDR);
    chk(q, 16'h8000);
    poll(PCS_DEVAD, CTRL_REG_ADDR, RESET_BIT, 1'b0);
  endtask
  // media loopback: three frames must come back unchanged
  task automatic pmdLoop();
    int errs;
    int held;
    wr(PCS_DEVAD, TEST_REG_ADDR, {3'h0, LOOP_PMD, 10'h0});
    rd(PCS_DEVAD, TEST_REG_ADDR);
    chk({13'h0, q[12:10]}, {13'h0, LOOP_PMD});
    wr(PMA_DEVAD, CTRL_REG_ADDR, 16'h8000);
    poll(PMA_DEVAD, CTRL_REG_ADDR, RESET_BIT, 1'b0);
    poll(PMA_DEVAD, STAT_REG_ADDR, LINK_BIT, 1'b1);
    station.frame(1518, 1'b0);
    station.frame(64, 1'b0);
    station.frame(1518, 1'b1);
    for (int i = 0; i < 2000 && rxQ.size() < station.sentQ.size(); i++)
      @(negedge sys_clk);
    chk(16'(rxQ.size()), 16'(station.sentQ.size()));
    errs = 0;
    foreach (rxQ[i])
    begin
      chk({7'h0, rxQ[i]}, {7'h0, station.sentQ[i]});
      errs += int'(rxQ[i][8]);
    end
    chk(16'(errs), 16'h0001);
    chk({15'h0, fifoOverflow}, 16'h0000);
    // all-zero test mode must keep gmii input out of the loop path
    wr(PCS_DEVAD, TEST_REG_ADDR, {TEST_ZERO, LOOP_PMD, 10'h0});
    held = rxQ.size();
    station.frame(64, 1'b0);
    repeat (100) @(negedge sys_clk);
    chk(16'(rxQ.size()), 16'(held));
    chk({14'h0, txSymbol}, {14'h0, SYM_ZERO});
  endtask
  initial
  begin
    repeat (6) @(negedge sys_clk);
    rst = 1'b0; // management held off until reset has gone
    resetDefaults();
    testModes();
    pmdLoop();
    complete_run();
  end
endmodule
